// file: flt_cfg.svh
/*
 * Constants for the four-mode logic timer bank: register map, field
 * positions, reset values and time base figures.
 * Assumes it is included by bare name wherever one of them is used.
 */
`ifndef FLT_CFG_SVH
`define FLT_CFG_SVH

// ----------------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------------
`define FLT_ADDR_W 12
`define FLT_ADDR_SEL 12'h000
`define FLT_ADDR_CTRL 12'h004
`define FLT_ADDR_CONST 12'h008
`define FLT_ADDR_ELAPSED 12'h00c
`define FLT_ADDR_STATUS 12'h010

// ----------------------------------------------------------------------
// field layout
// ----------------------------------------------------------------------
`define FLT_CTRL_W 6
`define FLT_STAT_BIT 0
`define FLT_STAT_MODE_LO 4
`define FLT_STAT_STATE_LO 8
`define FLT_TRIG_MONO 0
`define FLT_TRIG_DON 1
`define FLT_TRIG_DOFF 2
`define FLT_TRIG_LIMIT 3

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define FLT_RST_CTRL 6'h01
`define FLT_RST_WORD 32'h0000_0000
`define FLT_RST_SEL 8'h00

// ----------------------------------------------------------------------
// time base
// ----------------------------------------------------------------------
`define FLT_CLK_MHZ 40
`define FLT_TICK_US 1000
`define FLT_NUM_TIMERS 256
`define FLT_TIME_W 32

`endif

// file: flt_pkg.sv
/*
 * Types shared by the timer bank: input level bundle, mode and state.
 * Assumes nothing of its surroundings.
 */
package flt_pkg;

    // input levels of one timer as the program drives them
    typedef struct packed {
        logic [3:0] trig;
        logic reset;
        logic enable;
    } flt_inputs_s;

    typedef enum logic [1:0] {
        FLT_MODE_MONO = 2'h0,
        FLT_MODE_DON = 2'h1,
        FLT_MODE_DOFF = 2'h2,
        FLT_MODE_LIMIT = 2'h3
    } flt_mode_e;

    // gray order along idle -> armed -> timing -> done
    typedef enum logic [1:0] {
        FLT_ST_IDLE = 2'h0,
        FLT_ST_ARMED = 2'h1,
        FLT_ST_TIMING = 2'h3,
        FLT_ST_DONE = 2'h2
    } flt_state_e;

endpackage

// file: flt_prog_model.sv
/*
 * Model of the controller program: an APB master that writes timer input
 * levels and reads timer values, one aligned word per transfer.
 * Assumes a single rising-edge clock shared with the timer bank.
 */
`timescale 1ns/1ps
`include "flt_cfg.svh"

module flt_prog_model (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [`FLT_ADDR_W-1:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
    end

    // ------------------------------------------------------------------
    // one transfer
    // ------------------------------------------------------------------
    // constant and levels held until pready
    task automatic xfer(input logic wr, input logic [`FLT_ADDR_W-1:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines must not keep the last value
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

// file: flt_timer_bank.sv
/*
 * Bank of four-mode logic timers behind an APB slave, plus the timer cell.
 * Assumes one 40 MHz clock, an asynchronous active-low reset and a
 * program that writes input levels one timer at a time through SEL/CTRL.
 *
 */
`timescale 1ns/1ps
`include "flt_cfg.svh"

module flt_timer_cell #(
    parameter int TW = `FLT_TIME_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ms_tick,
    input wire logic ctrl_wr,
    input wire flt_pkg::flt_inputs_s ctrl_wdata,
    input wire logic const_wr,
    input wire logic [TW-1:0] const_wdata,
    output flt_pkg::flt_inputs_s levels,
    output logic [TW-1:0] elapsed,
    output logic status,
    output flt_pkg::flt_mode_e mode,
    output flt_pkg::flt_state_e state
);
    flt_pkg::flt_inputs_s lv_r, lv_in, lv_nxt;
    flt_pkg::flt_mode_e mode_r, mode_nxt, act_mode;
    flt_pkg::flt_state_e state_r, state_nxt;
    logic [TW-1:0] const_r, const_in, limit_r, elapsed_r, elapsed_nxt;
    logic status_r, status_nxt, load_limit, rst_rise, activate, expire;
    logic [3:0] rise, fall;

    // ------------------------------------------------------------------
    // edge detection on written levels
    // ------------------------------------------------------------------
    always_comb begin
        lv_in = ctrl_wr ? ctrl_wdata : lv_r;
        const_in = const_wr ? const_wdata : const_r;
    end

    assign rst_rise = lv_in.reset & ~lv_r.reset;
    assign rise = lv_in.trig & ~lv_r.trig;
    assign fall = ~lv_in.trig & lv_r.trig;
    assign activate = ~rst_rise & (|rise) &
                      ((state_r == flt_pkg::FLT_ST_IDLE) | (state_r == flt_pkg::FLT_ST_DONE));
    assign expire = (state_r == flt_pkg::FLT_ST_TIMING) & lv_r.enable & (elapsed_r >= limit_r);

    // lowest trigger wins if several rise together
    always_comb begin
        if (rise[`FLT_TRIG_MONO]) begin
            act_mode = flt_pkg::FLT_MODE_MONO;
        end else if (rise[`FLT_TRIG_DON]) begin
            act_mode = flt_pkg::FLT_MODE_DON;
        end else if (rise[`FLT_TRIG_DOFF]) begin
            act_mode = flt_pkg::FLT_MODE_DOFF;
        end else begin
            act_mode = flt_pkg::FLT_MODE_LIMIT;
        end
    end

    // ------------------------------------------------------------------
    // input levels
    // ------------------------------------------------------------------
    always_comb begin
        lv_nxt = lv_in;
        if (rst_rise) begin
            lv_nxt.trig = '0;
        end else if (activate) begin
            lv_nxt.enable = 1'b1;
            lv_nxt.reset = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lv_r <= `FLT_RST_CTRL;
        end else begin
            lv_r <= lv_nxt;
        end
    end

    // ------------------------------------------------------------------
    // time constant
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            const_r <= TW'(`FLT_RST_WORD);
        end else if (const_wr) begin
            const_r <= const_wdata;
        end
    end

    // constant latched at the trigger edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            limit_r <= TW'(`FLT_RST_WORD);
        end else if (load_limit) begin
            limit_r <= const_in;
        end
    end

    // ------------------------------------------------------------------
    // mode sequencing
    // ------------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        status_nxt = status_r;
        elapsed_nxt = elapsed_r;
        mode_nxt = mode_r;
        load_limit = 1'b0;
        if (rst_rise) begin
            state_nxt = flt_pkg::FLT_ST_IDLE;
            status_nxt = 1'b0;
            elapsed_nxt = '0;
        end else if (activate) begin
            mode_nxt = act_mode;
            elapsed_nxt = '0;
            load_limit = 1'b1;
            case (act_mode)
                flt_pkg::FLT_MODE_DON: begin
                    state_nxt = flt_pkg::FLT_ST_TIMING;
                    status_nxt = 1'b0;
                end
                flt_pkg::FLT_MODE_DOFF: begin
                    state_nxt = flt_pkg::FLT_ST_ARMED;
                    status_nxt = 1'b1;
                end
                default: begin
                    state_nxt = flt_pkg::FLT_ST_TIMING;
                    status_nxt = 1'b1;
                end
            endcase
        end else begin
            case (state_r)
                flt_pkg::FLT_ST_ARMED: begin
                    if (fall[`FLT_TRIG_DOFF]) begin
                        state_nxt = flt_pkg::FLT_ST_TIMING;
                        elapsed_nxt = '0;
                    end
                end
                flt_pkg::FLT_ST_TIMING: begin
                    if (mode_r == flt_pkg::FLT_MODE_DOFF && rise[`FLT_TRIG_DOFF]) begin
                        state_nxt = flt_pkg::FLT_ST_ARMED;
                        elapsed_nxt = '0;
                        load_limit = 1'b1;
                    end else if (mode_r == flt_pkg::FLT_MODE_DON && fall[`FLT_TRIG_DON]) begin
                        state_nxt = flt_pkg::FLT_ST_DONE;
                        status_nxt = 1'b0;
                    end else if (mode_r == flt_pkg::FLT_MODE_LIMIT && fall[`FLT_TRIG_LIMIT]) begin
                        state_nxt = flt_pkg::FLT_ST_DONE;
                        status_nxt = 1'b0;
                    end else if (expire) begin
                        state_nxt = flt_pkg::FLT_ST_DONE;
                        status_nxt = (mode_r == flt_pkg::FLT_MODE_DON);
                    end else if (ms_tick && lv_r.enable) begin
                        // count only on tick with enable
                        elapsed_nxt = elapsed_r + TW'(1);
                    end
                end
                flt_pkg::FLT_ST_DONE: begin
                    // delayed-on output held until trigger falls
                    if (mode_r == flt_pkg::FLT_MODE_DON && fall[`FLT_TRIG_DON]) begin
                        status_nxt = 1'b0;
                    end
                end
                default: begin
                    state_nxt = state_r;
                end
            endcase
        end
    end

    // monostable edges while timing fall through untouched
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= flt_pkg::FLT_ST_IDLE;
            mode_r <= flt_pkg::FLT_MODE_MONO;
            status_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            mode_r <= mode_nxt;
            status_r <= status_nxt;
        end
    end

    // elapsed time kept apart from status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            elapsed_r <= TW'(`FLT_RST_WORD);
        end else begin
            elapsed_r <= elapsed_nxt;
        end
    end

    assign levels = lv_r;
    assign elapsed = elapsed_r;
    assign status = status_r;
    assign mode = mode_r;
    assign state = state_r;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_act(flt_pkg::flt_mode_e m);
        activate && act_mode == m;
    endsequence

    sequence s_timing_quiet;
        state_r == flt_pkg::FLT_ST_TIMING && !rst_rise && rise == 4'h0 && fall == 4'h0;
    endsequence

    a_reset_clears: assert property (rst_rise |=> !status_r && elapsed_r == '0 && state_r == flt_pkg::FLT_ST_IDLE)
        else $error("reset input edge did not clear timer");
    a_trig_forced: assert property (rst_rise |=> lv_r.trig == 4'h0)
        else $error("triggers not forced low on reset edge");
    a_mono_start: assert property (s_act(flt_pkg::FLT_MODE_MONO) |=> status_r && elapsed_r == '0)
        else $error("monostable did not start");
    a_mono_ignore: assert property ((state_r == flt_pkg::FLT_ST_TIMING && mode_r == flt_pkg::FLT_MODE_MONO
        && !rst_rise && !expire) |=> status_r && state_r == flt_pkg::FLT_ST_TIMING)
        else $error("monostable reacted to trigger while timing");
    a_expire_hold: assert property ((expire && !rst_rise && mode_r != flt_pkg::FLT_MODE_DON
        && rise == 4'h0 && fall == 4'h0) |=> !status_r && elapsed_r == $past(elapsed_r))
        else $error("expiry did not drop status with count held");
    a_freeze_count: assert property ((s_timing_quiet and !lv_r.enable) |=> $stable(elapsed_r))
        else $error("count moved while disabled");
    a_don_start: assert property (s_act(flt_pkg::FLT_MODE_DON) |=> !status_r && elapsed_r == '0
        ##1 (!status_r || limit_r == '0))
        else $error("delayed-on raised status at start");
    a_doff_rearm: assert property ((state_r == flt_pkg::FLT_ST_TIMING && mode_r == flt_pkg::FLT_MODE_DOFF
        && rise[`FLT_TRIG_DOFF] && !rst_rise) |=> status_r && elapsed_r == '0
        && state_r == flt_pkg::FLT_ST_ARMED)
        else $error("delayed-off did not re-arm");
    a_limit_fall: assert property ((state_r == flt_pkg::FLT_ST_TIMING && mode_r == flt_pkg::FLT_MODE_LIMIT
        && fall[`FLT_TRIG_LIMIT] && !rst_rise) |=> !status_r && elapsed_r == $past(elapsed_r))
        else $error("limiting fall did not end timing");
    a_enable_forced: assert property (activate |=> lv_r.enable && !lv_r.reset)
        else $error("activation did not force enable and reset");
    a_tick_count: assert property ((s_timing_quiet and !expire and lv_r.enable and ms_tick)
        |=> elapsed_r == $past(elapsed_r) + TW'(1))
        else $error("count did not advance on tick");
endmodule

module flt_timer_bank #(
    parameter int NUM_TIMERS = `FLT_NUM_TIMERS,
    parameter int TW = `FLT_TIME_W,
    parameter int TICK_CYCLES = `FLT_CLK_MHZ * `FLT_TICK_US
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`FLT_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [NUM_TIMERS-1:0] timer_status
);
    localparam int SW = $clog2(NUM_TIMERS);
    localparam int CW = $clog2(TICK_CYCLES);

    logic [SW-1:0] sel_r;
    logic [CW-1:0] tick_cnt_r;
    logic ms_tick_r, wr_en, setup, err_nxt;
    logic [31:0] rd_nxt;
    flt_pkg::flt_inputs_s lv_all [NUM_TIMERS];
    logic [TW-1:0] elapsed_all [NUM_TIMERS];
    flt_pkg::flt_mode_e mode_all [NUM_TIMERS];
    flt_pkg::flt_state_e state_all [NUM_TIMERS];

    // ------------------------------------------------------------------
    // millisecond time base
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_r <= '0;
            ms_tick_r <= 1'b0;
        end else if (tick_cnt_r == CW'(TICK_CYCLES - 1)) begin
            tick_cnt_r <= '0;
            ms_tick_r <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + CW'(1);
            ms_tick_r <= 1'b0;
        end
    end

    a_tick_period: assert property (@(posedge pclk) disable iff (!presetn)
        ms_tick_r |=> !ms_tick_r [*8])
        else $error("millisecond tick repeated too soon");

    // ------------------------------------------------------------------
    // apb slave, zero wait states, read data captured in setup
    // ------------------------------------------------------------------
    assign pready = 1'b1;
    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_r <= SW'(`FLT_RST_SEL);
        end else if (wr_en && paddr == `FLT_ADDR_SEL) begin
            sel_r <= pwdata[SW-1:0];
        end
    end

    // elapsed and status answer at separate addresses
    always_comb begin
        rd_nxt = '0;
        err_nxt = 1'b0;
        if (paddr == `FLT_ADDR_SEL) begin
            rd_nxt[SW-1:0] = sel_r;
        end else if (paddr == `FLT_ADDR_CTRL) begin
            rd_nxt[`FLT_CTRL_W-1:0] = lv_all[sel_r];
        end else if (paddr == `FLT_ADDR_CONST) begin
            rd_nxt = 32'(0);
            err_nxt = pwrite ? 1'b0 : 1'b1;
        end else if (paddr == `FLT_ADDR_ELAPSED) begin
            rd_nxt[TW-1:0] = elapsed_all[sel_r];
        end else if (paddr == `FLT_ADDR_STATUS) begin
            rd_nxt[`FLT_STAT_BIT] = timer_status[sel_r];
            rd_nxt[`FLT_STAT_MODE_LO +: 2] = mode_all[sel_r];
            rd_nxt[`FLT_STAT_STATE_LO +: 2] = state_all[sel_r];
        end else begin
            err_nxt = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= `FLT_RST_WORD;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata <= pwrite ? `FLT_RST_WORD : rd_nxt;
            pslverr <= err_nxt;
        end
    end

    // ------------------------------------------------------------------
    // timer array
    // ------------------------------------------------------------------
    // independent timers, one cell each
    for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_timer
        flt_timer_cell #(.TW(TW)) u_cell (
            .pclk(pclk), .presetn(presetn), .ms_tick(ms_tick_r),
            .ctrl_wr(wr_en && paddr == `FLT_ADDR_CTRL && sel_r == SW'(i)), .ctrl_wdata(pwdata[`FLT_CTRL_W-1:0]),
            .const_wr(wr_en && paddr == `FLT_ADDR_CONST && sel_r == SW'(i)), .const_wdata(pwdata[TW-1:0]),
            .levels(lv_all[i]), .elapsed(elapsed_all[i]), .status(timer_status[i]),
            .mode(mode_all[i]), .state(state_all[i])
        );
    end
endmodule

// file: flt_timer_bank_bench.sv
/*
 * Self-checking bench for the timer bank: mode walks, reset and enable
 * behaviour, bus refusals.
 * Assumes a shortened tick of 10 clocks and a bank of 4 timers.
 */
`timescale 1ns/1ps
`include "flt_cfg.svh"

module flt_timer_bank_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, err;
    logic [`FLT_ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] timer_status;
    int num_errors = 0;
    int samples_checked = 0;
    int sel_idx = 0;

    initial forever #12.5 pclk = ~pclk;

    flt_timer_bank #(.NUM_TIMERS(4), .TICK_CYCLES(10)) i_flt_timer_bank (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer_status(timer_status));

    flt_prog_model i_flt_prog_model (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [`FLT_ADDR_W-1:0] a, input logic [31:0] d);
        i_flt_prog_model.xfer(1'b1, a, d, rd, err);
    endtask

    task automatic rd_chk(input string what, input logic [`FLT_ADDR_W-1:0] a, input logic [31:0] exp);
        i_flt_prog_model.xfer(1'b0, a, 32'h0, rd, err);
        check(what, exp, rd);
    endtask

    // status bit and mode field, plus the status pin of the selected timer
    task automatic st_chk(input logic st, input flt_pkg::flt_mode_e m);
        i_flt_prog_model.xfer(1'b0, `FLT_ADDR_STATUS, 32'h0, rd, err);
        check("status", {26'h0, m, 3'h0, st}, rd & 32'h0000_0031);
        check("status pin", {31'h0, st}, {31'h0, timer_status[sel_idx]});
    endtask

    task automatic pick(input int i);
        sel_idx = i;
        wr(`FLT_ADDR_SEL, 32'(i));
    endtask

    task automatic run(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic close_out;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        run(20000);
        num_errors++;
        close_out();
    end

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    initial begin
        run(3);
        presetn <= 1'b1;
        pick(0);
        rd_chk("ctrl reset", `FLT_ADDR_CTRL, 32'h01);
        rd_chk("elapsed reset", `FLT_ADDR_ELAPSED, 32'h0);
        st_chk(1'b0, flt_pkg::FLT_MODE_MONO);
        i_flt_prog_model.xfer(1'b0, 12'h020, 32'h0, rd, err);
        check("unmapped error", 32'h1, {31'h0, err});
        i_flt_prog_model.xfer(1'b0, `FLT_ADDR_CONST, 32'h0, rd, err);
        check("const read error", 32'h1, {31'h0, err});
        wr(`FLT_ADDR_CONST, 32'h3);
        wr(`FLT_ADDR_CTRL, 32'h05);
        st_chk(1'b1, flt_pkg::FLT_MODE_MONO);
        wr(`FLT_ADDR_CTRL, 32'h01);
        wr(`FLT_ADDR_CTRL, 32'h05);
        st_chk(1'b1, flt_pkg::FLT_MODE_MONO);
        run(50);
        st_chk(1'b0, flt_pkg::FLT_MODE_MONO);
        rd_chk("mono elapsed", `FLT_ADDR_ELAPSED, 32'h3);
        wr(`FLT_ADDR_CTRL, 32'h01);
        wr(`FLT_ADDR_CTRL, 32'h05);
        st_chk(1'b1, flt_pkg::FLT_MODE_MONO);
        wr(`FLT_ADDR_CTRL, 32'h07);
        st_chk(1'b0, flt_pkg::FLT_MODE_MONO);
        rd_chk("elapsed cleared", `FLT_ADDR_ELAPSED, 32'h0);
        rd_chk("triggers forced", `FLT_ADDR_CTRL, 32'h03);
        wr(`FLT_ADDR_CONST, 32'h5);
        // reset left high and enable low: activation has to force both
        wr(`FLT_ADDR_CTRL, 32'h06);
        rd_chk("activation levels", `FLT_ADDR_CTRL, 32'h05);
        wr(`FLT_ADDR_CTRL, 32'h04);
        run(80);
        rd_chk("frozen elapsed", `FLT_ADDR_ELAPSED, 32'h1);
        run(40);
        rd_chk("still frozen", `FLT_ADDR_ELAPSED, 32'h1);
        st_chk(1'b1, flt_pkg::FLT_MODE_MONO);
        wr(`FLT_ADDR_CTRL, 32'h05);
        run(70);
        st_chk(1'b0, flt_pkg::FLT_MODE_MONO);
        rd_chk("resumed elapsed", `FLT_ADDR_ELAPSED, 32'h5);
        pick(1);
        wr(`FLT_ADDR_CONST, 32'h2);
        wr(`FLT_ADDR_CTRL, 32'h09);
        st_chk(1'b0, flt_pkg::FLT_MODE_DON);
        run(40);
        st_chk(1'b1, flt_pkg::FLT_MODE_DON);
        rd_chk("don elapsed", `FLT_ADDR_ELAPSED, 32'h2);
        wr(`FLT_ADDR_CTRL, 32'h01);
        st_chk(1'b0, flt_pkg::FLT_MODE_DON);
        wr(`FLT_ADDR_CONST, 32'h32);
        wr(`FLT_ADDR_CTRL, 32'h09);
        run(15);
        wr(`FLT_ADDR_CTRL, 32'h01);
        st_chk(1'b0, flt_pkg::FLT_MODE_DON);
        rd_chk("don early elapsed", `FLT_ADDR_ELAPSED, 32'h1);
        run(30);
        rd_chk("don early held", `FLT_ADDR_ELAPSED, 32'h1);
        pick(2);
        wr(`FLT_ADDR_CONST, 32'h2);
        wr(`FLT_ADDR_CTRL, 32'h11);
        st_chk(1'b1, flt_pkg::FLT_MODE_DOFF);
        run(40);
        rd_chk("doff no count", `FLT_ADDR_ELAPSED, 32'h0);
        wr(`FLT_ADDR_CTRL, 32'h01);
        // re-arm lands after one tick, well before the constant runs out
        run(2);
        wr(`FLT_ADDR_CTRL, 32'h11);
        st_chk(1'b1, flt_pkg::FLT_MODE_DOFF);
        rd_chk("doff rearm", `FLT_ADDR_ELAPSED, 32'h0);
        wr(`FLT_ADDR_CTRL, 32'h01);
        run(40);
        st_chk(1'b0, flt_pkg::FLT_MODE_DOFF);
        rd_chk("doff elapsed", `FLT_ADDR_ELAPSED, 32'h2);
        pick(3);
        wr(`FLT_ADDR_CONST, 32'h1);
        wr(`FLT_ADDR_CTRL, 32'h21);
        st_chk(1'b1, flt_pkg::FLT_MODE_LIMIT);
        run(30);
        st_chk(1'b0, flt_pkg::FLT_MODE_LIMIT);
        rd_chk("limit elapsed", `FLT_ADDR_ELAPSED, 32'h1);
        wr(`FLT_ADDR_CTRL, 32'h01);
        wr(`FLT_ADDR_CONST, 32'h32);
        wr(`FLT_ADDR_CTRL, 32'h21);
        run(25);
        wr(`FLT_ADDR_CTRL, 32'h01);
        st_chk(1'b0, flt_pkg::FLT_MODE_LIMIT);
        rd_chk("limit early elapsed", `FLT_ADDR_ELAPSED, 32'h3);
        run(30);
        rd_chk("limit early held", `FLT_ADDR_ELAPSED, 32'h3);
        wr(`FLT_ADDR_CONST, 32'hffff_ffff);
        wr(`FLT_ADDR_CTRL, 32'h21);
        run(30);
        st_chk(1'b1, flt_pkg::FLT_MODE_LIMIT);
        check("bank pins", 32'h8, {28'h0, timer_status});
        wr(`FLT_ADDR_CTRL, 32'h01);
        wr(`FLT_ADDR_CONST, 32'h0);
        wr(`FLT_ADDR_CTRL, 32'h21);
        run(3);
        st_chk(1'b0, flt_pkg::FLT_MODE_LIMIT);
        rd_chk("zero const elapsed", `FLT_ADDR_ELAPSED, 32'h0);
        close_out();
    end
endmodule
